// >>> rtl/ccs_defines.svh
// ccs_defines.svh: reset values and timing counts of the cpu clock source switch
// assumes a 200 MHz reference clock; included by its bare name
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CCS_RST_CPU_CLK 1'h0
`define CCS_RST_ON_FAST 1'h0
`define CCS_RST_FAST_RUN 1'h0
`define CCS_RST_SUPPLY_HIGH 1'h0
`define CCS_RST_SETTLED 1'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CCS_CLK_PERIOD_PS 64'h1388
// regulator settling before the fast oscillator is started, 2.5 ms
`define CCS_REG_SETTLE_US 64'h9C4
// fast oscillator start-up before it may clock the cpu, 5 ms
`define CCS_FAST_STABLE_US 64'h1388
`define CCS_PS_PER_US 64'hF4240
// least times round up to whole cycles
`define CCS_REG_SETTLE_CYC \
   ((`CCS_REG_SETTLE_US * `CCS_PS_PER_US + `CCS_CLK_PERIOD_PS - 64'h1) / `CCS_CLK_PERIOD_PS)
`define CCS_FAST_STABLE_CYC \
   ((`CCS_FAST_STABLE_US * `CCS_PS_PER_US + `CCS_CLK_PERIOD_PS - 64'h1) / `CCS_CLK_PERIOD_PS)
`define CCS_CNT_W 20

`endif

// >>> rtl/ccs_pkg.sv
// ccs_pkg: types of the cpu clock source switch
// assumes ccs_defines.svh is on the include path
package ccs_pkg;

   // ----------------------------------------------------------------------
   // switch states, gray coded along slow -> fast -> slow
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      CCS_SLOW = 2'h0,
      CCS_PARK_TO_FAST = 2'h1,
      CCS_FAST = 2'h3,
      CCS_PARK_TO_SLOW = 2'h2
   } ccs_state_t;

   // ----------------------------------------------------------------------
   // control settings written by software
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic cpu_clock_select;
      logic fast_osc_enable;
      logic regulator_level_select;
   } ccs_ctrl_t;

endpackage : ccs_pkg

// >>> rtl/ccs_switch.sv
// ccs_switch: chooses the oscillator that clocks the cpu and sets the
// oscillator system regulator level
// assumes both oscillator waveforms are far slower than REF_CLK_I, and
// that CTRL_I comes from logic on REF_CLK_I
//
// Overview of operation
// - reset: cpu on slow oscillator, select zero
// - reset: fast oscillator stopped, enable zero
// - reset: regulator select zero, low 1.3 V level
// - rc option: regulator fixed high, select ignored
`timescale 1ns/1ps
`include "ccs_defines.svh"

module ccs_switch #(
   parameter logic [`CCS_CNT_W-1:0] REG_SETTLE_CYCLES = `CCS_CNT_W'(`CCS_REG_SETTLE_CYC),
   parameter logic [`CCS_CNT_W-1:0] FAST_STABLE_CYCLES = `CCS_CNT_W'(`CCS_FAST_STABLE_CYC)
) (
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire ccs_pkg::ccs_ctrl_t CTRL_I,
   input wire logic RC_OSC_OPTION_I,
   input wire logic SLOW_OSCILLATOR_I,
   input wire logic FAST_OSCILLATOR_I,
   output logic CPU_CLK_O,
   output logic CPU_ON_FAST_O,
   output logic FAST_OSC_RUN_O,
   output logic SUPPLY_HIGH_O,
   output logic SUPPLY_SETTLED_O,
   output logic FAST_OSC_STABLE_O
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // saturating count, held at zero while the condition is away
   function automatic logic [`CCS_CNT_W-1:0] sat_count(
      input logic run,
      input logic [`CCS_CNT_W-1:0] cnt,
      input logic [`CCS_CNT_W-1:0] lim
   );
      logic [`CCS_CNT_W-1:0] res;
      res = '0;
      if (run) begin
         res = (cnt >= lim) ? lim : cnt + `CCS_CNT_W'(1);
      end
      return res;
   endfunction : sat_count

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [2:0] pins_raw;
   logic [2:0] pins_s;
   logic slow_s;
   logic fast_s;
   logic rc_option_s;

   assign pins_raw = {RC_OSC_OPTION_I, FAST_OSCILLATOR_I, SLOW_OSCILLATOR_I};

   ccs_sync #(
      .W(3)
   ) u_sync (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .d_i(pins_raw),
      .q_o(pins_s)
   );

   assign slow_s = pins_s[0];
   assign fast_s = pins_s[1];
   assign rc_option_s = pins_s[2];

   // ----------------------------------------------------------------------
   // regulator level
   // ----------------------------------------------------------------------
   logic next_supply_high;

   // rc slow oscillator pins the regulator high whatever software writes
   assign next_supply_high = rc_option_s | CTRL_I.regulator_level_select;

   // ----------------------------------------------------------------------
   // settling timers, shown to software as status
   // ----------------------------------------------------------------------
   logic [`CCS_CNT_W-1:0] reg_cnt;
   logic [`CCS_CNT_W-1:0] fast_cnt;
   logic [`CCS_CNT_W-1:0] next_reg_cnt;
   logic [`CCS_CNT_W-1:0] next_fast_cnt;
   logic next_supply_settled;
   logic next_fast_stable;

   // time the regulator has been high, and the fast oscillator running
   assign next_reg_cnt = sat_count(SUPPLY_HIGH_O, reg_cnt, REG_SETTLE_CYCLES);
   assign next_fast_cnt = sat_count(FAST_OSC_RUN_O, fast_cnt, FAST_STABLE_CYCLES);
   assign next_supply_settled = next_supply_high && (next_reg_cnt >= REG_SETTLE_CYCLES);
   assign next_fast_stable = CTRL_I.fast_osc_enable && (next_fast_cnt >= FAST_STABLE_CYCLES);

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         reg_cnt <= '0;
         fast_cnt <= '0;
      end else begin
         reg_cnt <= next_reg_cnt;
         fast_cnt <= next_fast_cnt;
      end
   end

   // ----------------------------------------------------------------------
   // glitch-free source switch
   // ----------------------------------------------------------------------
   // the cpu clock is parked low between sources: the old source is left
   // only while it is low, the new one is taken only while it is low, so
   // no shortened high or low phase reaches the cpu
   ccs_pkg::ccs_state_t state;
   ccs_pkg::ccs_state_t next_state;
   logic want_fast;
   logic slow_to_park;
   logic park_to_fast;
   logic park_abort;
   logic fast_to_park;
   logic park_to_slow;
   logic in_slow;
   logic in_fast;
   logic next_cpu_clk;
   logic next_on_fast;

   // the fast source is wanted only while it is also enabled, so software
   // that stops it before dropping the select still leads the switch home;
   // the switch then waits for the fast pin to sit low, so an oscillator
   // that stops high holds the cpu clock high until it runs again
   assign want_fast = CTRL_I.cpu_clock_select & CTRL_I.fast_osc_enable;

   // ----------------------------------------------------------------------
   // switch transitions
   // ----------------------------------------------------------------------
   // each source is left or taken only while its synchronised level is low,
   // which is what keeps runt pulses off the cpu clock
   assign slow_to_park = want_fast & ~slow_s;
   assign park_to_fast = want_fast & ~fast_s;
   // a park entered by a select that was withdrawn heads back to slow at once
   assign park_abort = ~want_fast;
   assign fast_to_park = ~want_fast & ~fast_s;
   assign park_to_slow = ~slow_s;

   always_comb begin
      next_state = state;
      unique case (state)
         ccs_pkg::CCS_SLOW: begin
            if (slow_to_park) begin
               next_state = ccs_pkg::CCS_PARK_TO_FAST;
            end
         end
         ccs_pkg::CCS_PARK_TO_FAST: begin
            if (park_abort) begin
               next_state = ccs_pkg::CCS_PARK_TO_SLOW;
            end else if (park_to_fast) begin
               next_state = ccs_pkg::CCS_FAST;
            end
         end
         ccs_pkg::CCS_FAST: begin
            if (fast_to_park) begin
               next_state = ccs_pkg::CCS_PARK_TO_SLOW;
            end
         end
         ccs_pkg::CCS_PARK_TO_SLOW: begin
            if (park_to_slow) begin
               next_state = ccs_pkg::CCS_SLOW;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // cpu clock source
   // ----------------------------------------------------------------------
   // both parking states hold the cpu clock low, so the low phase around a
   // change of source is stretched, never shortened
   assign in_slow = (state == ccs_pkg::CCS_SLOW);
   assign in_fast = (state == ccs_pkg::CCS_FAST);
   assign next_cpu_clk = (in_slow & slow_s) | (in_fast & fast_s);
   assign next_on_fast = (next_state == ccs_pkg::CCS_FAST);

   // ----------------------------------------------------------------------
   // state and output registers
   // ----------------------------------------------------------------------
   // switch state and the cpu clock itself; the clock output is the chosen
   // synchronised source one cycle late, or low while parked
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state <= ccs_pkg::CCS_SLOW;
         CPU_CLK_O <= `CCS_RST_CPU_CLK;
         CPU_ON_FAST_O <= `CCS_RST_ON_FAST;
      end else begin
         state <= next_state;
         CPU_CLK_O <= next_cpu_clk;
         CPU_ON_FAST_O <= next_on_fast;
      end
   end

   // fast oscillator enable and its start-up status
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         FAST_OSC_RUN_O <= `CCS_RST_FAST_RUN;
         FAST_OSC_STABLE_O <= `CCS_RST_SETTLED;
      end else begin
         FAST_OSC_RUN_O <= CTRL_I.fast_osc_enable;
         FAST_OSC_STABLE_O <= next_fast_stable;
      end
   end

   // regulator level and its settling status
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         SUPPLY_HIGH_O <= `CCS_RST_SUPPLY_HIGH;
         SUPPLY_SETTLED_O <= `CCS_RST_SETTLED;
      end else begin
         SUPPLY_HIGH_O <= next_supply_high;
         SUPPLY_SETTLED_O <= next_supply_settled;
      end
   end

endmodule : ccs_switch

// >>> rtl/ccs_sync.sv
// ccs_sync: two flip-flop synchroniser for a group of levels
// assumes the inputs are static for at least two reference cycles per level
`timescale 1ns/1ps

module ccs_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule : ccs_sync

// >>> tb/ccs_switch_sva.sv
// ccs_switch_sva: port assertions for ccs_switch
// assumes oscillator half periods of three or more reference cycles
`timescale 1ns/1ps
module ccs_switch_sva #(
   parameter int REG_SETTLE_CYCLES = 20,
   parameter int FAST_STABLE_CYCLES = 40
) (
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire ccs_pkg::ccs_ctrl_t CTRL_I,
   input wire logic RC_OSC_OPTION_I,
   input wire logic CPU_CLK_O,
   input wire logic CPU_ON_FAST_O,
   input wire logic FAST_OSC_RUN_O,
   input wire logic SUPPLY_HIGH_O,
   input wire logic SUPPLY_SETTLED_O,
   input wire logic FAST_OSC_STABLE_O
);
   int run_cnt;
   int sup_cnt;
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         run_cnt <= 0;
         sup_cnt <= 0;
      end else begin
         run_cnt <= FAST_OSC_RUN_O ? run_cnt + 1 : 0;
         sup_cnt <= SUPPLY_HIGH_O ? sup_cnt + 1 : 0;
      end
   end
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);
   a_reset_state: assert property ($rose(RESETN_I) |-> !CPU_ON_FAST_O && !FAST_OSC_RUN_O)
      else $error("outputs not idle after reset");
   a_run_follows_en: assert property ($changed(CTRL_I.fast_osc_enable) |=>
      FAST_OSC_RUN_O == $past(CTRL_I.fast_osc_enable)) else $error("run not following enable");
   a_supply_raise: assert property ($rose(CTRL_I.regulator_level_select) |=> SUPPLY_HIGH_O)
      else $error("regulator did not rise");
   a_rc_fixed: assert property (RC_OSC_OPTION_I [*4] |-> SUPPLY_HIGH_O)
      else $error("regulator not fixed high");
   a_settle_time: assert property (SUPPLY_HIGH_O |->
      SUPPLY_SETTLED_O == (sup_cnt >= REG_SETTLE_CYCLES)) else $error("settle time wrong");
   a_stable_time: assert property (FAST_OSC_RUN_O |->
      FAST_OSC_STABLE_O == (run_cnt >= FAST_STABLE_CYCLES)) else $error("stable time wrong");
   a_switch_parked: assert property ($changed(CPU_ON_FAST_O) |-> !CPU_CLK_O)
      else $error("switch while clock high");
   a_no_runt: assert property ($changed(CPU_CLK_O) |=> $stable(CPU_CLK_O) [*2])
      else $error("runt cpu clock pulse");
   c_on_fast: cover property ($rose(CPU_ON_FAST_O));
   c_back_slow: cover property ($fell(CPU_ON_FAST_O));
   c_stable: cover property ($rose(FAST_OSC_STABLE_O));
endmodule : ccs_switch_sva

bind ccs_switch ccs_switch_sva #(.REG_SETTLE_CYCLES(REG_SETTLE_CYCLES),
   .FAST_STABLE_CYCLES(FAST_STABLE_CYCLES)) sva_u (.REF_CLK_I(REF_CLK_I),
   .RESETN_I(RESETN_I), .CTRL_I(CTRL_I), .RC_OSC_OPTION_I(RC_OSC_OPTION_I),
   .CPU_CLK_O(CPU_CLK_O), .CPU_ON_FAST_O(CPU_ON_FAST_O), .FAST_OSC_RUN_O(FAST_OSC_RUN_O),
   .SUPPLY_HIGH_O(SUPPLY_HIGH_O), .SUPPLY_SETTLED_O(SUPPLY_SETTLED_O),
   .FAST_OSC_STABLE_O(FAST_OSC_STABLE_O));

// >>> tb/ccs_switch_tb.sv
// ccs_switch_tb: directed bench for ccs_switch
// assumes short settle counts of 20 and 40 cycles
`timescale 1ns/1ps
module ccs_switch_tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   ccs_pkg::ccs_ctrl_t ctrl = '0;
   logic rc = 1'b0;
   logic slow = 1'b0;
   logic fast = 1'b0;
   logic cpu_clk, on_fast, run, sup, settled, stable;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   ccs_switch #(.REG_SETTLE_CYCLES(20'h14), .FAST_STABLE_CYCLES(20'h28)) dut_u (
      .REF_CLK_I(clk), .RESETN_I(rstn), .CTRL_I(ctrl), .RC_OSC_OPTION_I(rc),
      .SLOW_OSCILLATOR_I(slow), .FAST_OSCILLATOR_I(fast), .CPU_CLK_O(cpu_clk),
      .CPU_ON_FAST_O(on_fast), .FAST_OSC_RUN_O(run), .SUPPLY_HIGH_O(sup),
      .SUPPLY_SETTLED_O(settled), .FAST_OSC_STABLE_O(stable));
   task final_report;
      if (fail_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   // fast oscillator stays low while stopped
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 10 == 9)
         slow <= ~slow;
      fast <= run && (cyc % 8 >= 4);
      if (cyc == 3000) begin
         fail_count++;
         final_report();
      end
   end
   task chk(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %b expected %b", $time, got, exp);
      end
   endtask : chk
   task automatic wait_on(ref logic s, input logic v);
      for (int i = 0; i < 200 && s !== v; i++)
         @(negedge clk);
   endtask : wait_on
   task t_reset;
      rstn = 1'b0;
      ctrl = '0;
      repeat (3) @(negedge clk);
      // release only while the slow pin is low, so the first slow phase is whole
      while (slow !== 1'b0) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk(on_fast, 1'b0);
      chk(run, 1'b0);
      chk(sup, 1'b0);
   endtask : t_reset
   task t_no_enable;
      ctrl.cpu_clock_select = 1'b1;
      repeat (30) @(negedge clk);
      chk(on_fast, 1'b0);
      ctrl.cpu_clock_select = 1'b0;
   endtask : t_no_enable
   task t_to_fast;
      ctrl.regulator_level_select = 1'b1;
      repeat (20) @(negedge clk);
      chk(settled, 1'b0);
      @(negedge clk);
      chk(settled, 1'b1);
      ctrl.fast_osc_enable = 1'b1;
      @(negedge clk);
      chk(run, 1'b1);
      repeat (39) @(negedge clk);
      chk(stable, 1'b0);
      @(negedge clk);
      chk(stable, 1'b1);
      ctrl.cpu_clock_select = 1'b1;
      wait_on(on_fast, 1'b1);
      wait_on(cpu_clk, 1'b1);
      chk(on_fast & cpu_clk, 1'b1);
   endtask : t_to_fast
   task t_to_slow;
      ctrl.cpu_clock_select = 1'b0;
      wait_on(on_fast, 1'b0);
      chk(on_fast, 1'b0);
      chk(run, 1'b1);
      ctrl.fast_osc_enable = 1'b0;
      @(negedge clk);
      chk(run | stable, 1'b0);
      ctrl.regulator_level_select = 1'b0;
      @(negedge clk);
      chk(sup, 1'b0);
      wait_on(cpu_clk, 1'b1);
      chk(cpu_clk, 1'b1);
   endtask : t_to_slow
   task t_rc;
      rc = 1'b1;
      repeat (4) @(negedge clk);
      chk(sup, 1'b1);
      ctrl.regulator_level_select = 1'b1;
      @(negedge clk);
      ctrl.regulator_level_select = 1'b0;
      @(negedge clk);
      chk(sup, 1'b1);
      rc = 1'b0;
      repeat (4) @(negedge clk);
      chk(sup, 1'b0);
   endtask : t_rc
   // a select withdrawn while the switch is parked must never reach fast
   task t_abort;
      ctrl.cpu_clock_select = 1'b0;
      wait_on(on_fast, 1'b0);
      wait_on(cpu_clk, 1'b1);
      wait_on(cpu_clk, 1'b0);
      ctrl.cpu_clock_select = 1'b1;
      @(negedge clk);
      ctrl.cpu_clock_select = 1'b0;
      repeat (8) begin
         @(negedge clk);
         chk(on_fast, 1'b0);
      end
      wait_on(cpu_clk, 1'b1);
      chk(cpu_clk, 1'b1);
   endtask : t_abort
   initial begin
      t_reset();
      t_no_enable();
      t_to_fast();
      t_to_slow();
      t_rc();
      t_to_fast();
      t_abort();
      t_reset();
      final_report();
   end
endmodule : ccs_switch_tb
